/* File: cid_pkg.sv */
// Shared opcodes, types and helpers for the control instruction decoder
package cid_pkg;

  // Word and datapath widths
  localparam int CID_IW = 14;
  localparam int CID_PCW = 15;
  localparam int CID_PTRW = 16;

  // Opcode patterns, operand bits shown as don't-care
  localparam logic [13:0] OPC_BRA    = 14'b11_001?_????_????;
  localparam logic [13:0] OPC_BRW    = 14'b00_0000_0000_1011;
  localparam logic [13:0] OPC_CALL   = 14'b10_0???_????_????;
  localparam logic [13:0] OPC_CALL_VIA_ACCUMULATOR  = 14'b00_0000_0000_1010;
  localparam logic [13:0] OPC_GOTO   = 14'b10_1???_????_????;
  localparam logic [13:0] OPC_RETI   = 14'b00_0000_0000_1001;
  localparam logic [13:0] OPC_RETURN_WITH_LITERAL  = 14'b11_0100_????_????;
  localparam logic [13:0] OPC_RET    = 14'b00_0000_0000_1000;
  localparam logic [13:0] OPC_WDTCLR = 14'b00_0000_0110_0100;
  localparam logic [13:0] OPC_PRESC  = 14'b00_0000_0110_0010;
  localparam logic [13:0] OPC_SWRST  = 14'b00_0000_0000_0001;
  localparam logic [13:0] OPC_SLEEP  = 14'b00_0000_0110_0011;
  localparam logic [13:0] OPC_DIR    = 14'b00_0000_0110_0???;
  localparam logic [13:0] OPC_PADD   = 14'b11_0001_0???_????;
  localparam logic [13:0] OPC_ILD    = 14'b00_0000_0001_0???;
  localparam logic [13:0] OPC_IST    = 14'b00_0000_0001_1???;
  localparam logic [13:0] OPC_ILDX   = 14'b11_1111_0???_????;
  localparam logic [13:0] OPC_ISTX   = 14'b11_1111_1???_????;

  // Field positions inside the word
  localparam int F_PSEL_IDX = 6;
  localparam int F_PSEL_MOD = 2;
  localparam int F_K6_HI = 5;
  localparam int F_K8_HI = 7;
  localparam int F_K9_HI = 8;
  localparam int F_K11_HI = 10;
  localparam int F_DIR_HI = 2;
  localparam int F_MODE_HI = 1;

  // Status flag values at reset
  localparam logic CID_TO_RST = 1'b1;
  localparam logic CID_PD_RST = 1'b1;

  // Decoded operations
  typedef enum {
    OP_NONE, OP_BRA, OP_BRW, OP_CALL, OP_CALL_VIA_ACCUMULATOR, OP_GOTO, OP_RETI,
    OP_RETURN_WITH_LITERAL, OP_RET, OP_WDTCLR, OP_PRESC, OP_SWRST, OP_SLEEP, OP_DIR,
    OP_PADD, OP_ILD, OP_IST, OP_ILDX, OP_ISTX
  } cid_op_t;

  // Program-flow request to the sequencer outside
  typedef enum logic [2:0] {
    FLOW_NONE, FLOW_JUMP, FLOW_CALL, FLOW_RET, FLOW_RETI
  } cid_flow_t;

  // Sign-extend a six-bit literal to pointer width
  function automatic logic [15:0] cid_sext6(input logic [5:0] k);
    cid_sext6 = {{10{k[5]}}, k};
  endfunction

  // Sign-extend a nine-bit branch offset to program-counter width
  function automatic logic [14:0] cid_sext9(input logic [8:0] k);
    cid_sext9 = {{6{k[8]}}, k};
  endfunction

endpackage

/* File: cid_decode.sv */
// Opcode classifier for control, inherent and pointer instructions
`timescale 1ns/10ps
`default_nettype none
module cid_decode (
  // Fetched word
  input  wire logic [13:0]     word,
  // Decoded operation
  output var cid_pkg::cid_op_t op
);

  // Specific inherent words come before the direction-register pattern
  always_comb begin
    casez (word)
      cid_pkg::OPC_BRA:    op = cid_pkg::OP_BRA;
      cid_pkg::OPC_BRW:    op = cid_pkg::OP_BRW;
      cid_pkg::OPC_CALL:   op = cid_pkg::OP_CALL;
      cid_pkg::OPC_CALL_VIA_ACCUMULATOR:  op = cid_pkg::OP_CALL_VIA_ACCUMULATOR;
      cid_pkg::OPC_GOTO:   op = cid_pkg::OP_GOTO;
      cid_pkg::OPC_RETI:   op = cid_pkg::OP_RETI;
      cid_pkg::OPC_RETURN_WITH_LITERAL:  op = cid_pkg::OP_RETURN_WITH_LITERAL;
      cid_pkg::OPC_RET:    op = cid_pkg::OP_RET;
      cid_pkg::OPC_WDTCLR: op = cid_pkg::OP_WDTCLR;
      cid_pkg::OPC_PRESC:  op = cid_pkg::OP_PRESC;
      cid_pkg::OPC_SWRST:  op = cid_pkg::OP_SWRST;
      cid_pkg::OPC_SLEEP:  op = cid_pkg::OP_SLEEP;
      cid_pkg::OPC_DIR:    op = cid_pkg::OP_DIR;
      cid_pkg::OPC_PADD:   op = cid_pkg::OP_PADD;
      cid_pkg::OPC_ILD:    op = cid_pkg::OP_ILD;
      cid_pkg::OPC_IST:    op = cid_pkg::OP_IST;
      cid_pkg::OPC_ILDX:   op = cid_pkg::OP_ILDX;
      cid_pkg::OPC_ISTX:   op = cid_pkg::OP_ISTX;
      default:             op = cid_pkg::OP_NONE;
    endcase
  end

endmodule // cid_decode
`default_nettype wire

/* File: cid_core.sv */
// Sequencer for control, inherent and indirect-access instructions
`timescale 1ns/10ps
`default_nettype none
module cid_core (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Instruction fetch
  input  wire logic [13:0]         instr_word,
  input  wire logic                instr_valid,
  output logic                     fetch_ready_r,
  // Core context
  input  wire logic [14:0]         pc_cur,
  input  wire logic [7:0]          wacc_in,
  input  wire logic [7:0]          ind_rdata,
  // Program flow
  output var cid_pkg::cid_flow_t   flow_kind_r,
  output logic [14:0]              flow_target_r,
  // Accumulator and zero flag
  output logic                     wacc_load_r,
  output logic [7:0]               wacc_data_r,
  output logic                     zero_we_r,
  output logic                     zero_val_r,
  // System control
  output logic                     wdt_clear_r,
  output logic                     standby_r,
  output logic                     sw_reset_r,
  output logic                     timeout_flag_r,
  output logic                     powerdown_flag_r,
  output logic                     presc_we_r,
  output logic                     dir_we_r,
  output logic [2:0]               dir_sel_r,
  output logic [7:0]               cfg_data_r,
  // Indirect data access
  output logic                     mem_re_r,
  output logic                     mem_we_r,
  output logic [15:0]              mem_addr_r,
  output logic [7:0]               mem_wdata_r,
  output logic [15:0]              ptr0_r,
  output logic [15:0]              ptr1_r
);

  typedef enum {PH_RUN, PH_NOP, PH_EXT} cid_phase_t;

  typedef struct packed {
    cid_phase_t          phase;
    logic                ready;
    cid_pkg::cid_flow_t  flow_kind;
    logic [14:0]         flow_target;
    logic                wacc_load;
    logic [7:0]          wacc_data;
    logic                zero_we;
    logic                zero_val;
    logic                wdt_clear;
    logic                standby;
    logic                sw_reset;
    logic                to_flag;
    logic                pd_flag;
    logic                presc_we;
    logic                dir_we;
    logic [2:0]          dir_sel;
    logic [7:0]          cfg_data;
    logic                mem_re;
    logic                mem_we;
    logic [15:0]         mem_addr;
    logic [7:0]          mem_wdata;
    logic [15:0]         ptr0;
    logic [15:0]         ptr1;
    logic                ld_pend;
  } cid_state_t;

  cid_state_t          st_r;
  cid_state_t          st_nxt;
  cid_pkg::cid_op_t    op;
  logic                accept;
  logic                psel;
  logic [1:0]          mode;
  logic [5:0]          k6;
  logic [15:0]         ptr_sel;

  // Classify the fetched word
  cid_decode u_dec (
    .word (instr_word),
    .op   (op)
  );

  assign accept  = instr_valid && (st_r.phase == PH_RUN);
  assign psel    = instr_word[cid_pkg::F_PSEL_IDX];
  assign mode    = instr_word[cid_pkg::F_MODE_HI:0];
  assign k6      = instr_word[cid_pkg::F_K6_HI:0];
  assign ptr_sel = psel ? st_r.ptr1 : st_r.ptr0;

  // Pointer after one modifier step: even modes count up, odd down
  function automatic logic [15:0] step_ptr(input logic [15:0] p,
                                           input logic [1:0] m);
    step_ptr = m[0] ? p - 16'h0001 : p + 16'h0001;
  endfunction

  // Next-state logic
  always_comb begin
    logic          two;
    logic          ext;
    logic [15:0]   upd;
    logic [15:0]   addr;
    two = 1'b0;
    ext = 1'b0;
    upd = 16'h0000;
    addr = 16'h0000;
    st_nxt = st_r;
    st_nxt.flow_kind = cid_pkg::FLOW_NONE;
    st_nxt.wacc_load = 1'b0;
    st_nxt.zero_we = 1'b0;
    st_nxt.wdt_clear = 1'b0;
    st_nxt.sw_reset = 1'b0;
    st_nxt.presc_we = 1'b0;
    st_nxt.dir_we = 1'b0;
    st_nxt.mem_re = 1'b0;
    st_nxt.mem_we = 1'b0;
    st_nxt.ld_pend = 1'b0;
    // load capture: read data lands one cycle after the strobe
    if (st_r.ld_pend) begin
      st_nxt.wacc_load = 1'b1;
      st_nxt.wacc_data = ind_rdata;
      st_nxt.zero_we = 1'b1;
      st_nxt.zero_val = (ind_rdata == 8'h00);
    end
    case (st_r.phase)
      PH_RUN: begin
        if (accept) begin
          st_nxt.standby = 1'b0;
          case (op)
            cid_pkg::OP_BRA: begin
              two = 1'b1;
              st_nxt.flow_kind = cid_pkg::FLOW_JUMP;
              st_nxt.flow_target = pc_cur + 15'h0001 +
                cid_pkg::cid_sext9(instr_word[cid_pkg::F_K9_HI:0]);
            end
            cid_pkg::OP_BRW: begin
              two = 1'b1;
              st_nxt.flow_kind = cid_pkg::FLOW_JUMP;
              st_nxt.flow_target = pc_cur + 15'h0001 + {7'h00, wacc_in};
            end
            cid_pkg::OP_CALL, cid_pkg::OP_GOTO: begin
              two = 1'b1;
              st_nxt.flow_kind = (op == cid_pkg::OP_CALL) ?
                cid_pkg::FLOW_CALL : cid_pkg::FLOW_JUMP;
              st_nxt.flow_target = {pc_cur[14:11],
                instr_word[cid_pkg::F_K11_HI:0]};
            end
            cid_pkg::OP_CALL_VIA_ACCUMULATOR: begin
              two = 1'b1;
              st_nxt.flow_kind = cid_pkg::FLOW_CALL;
              st_nxt.flow_target = {pc_cur[14:8], wacc_in};
            end
            cid_pkg::OP_RETI: begin
              two = 1'b1;
              st_nxt.flow_kind = cid_pkg::FLOW_RETI;
            end
            cid_pkg::OP_RETURN_WITH_LITERAL: begin
              two = 1'b1;
              st_nxt.flow_kind = cid_pkg::FLOW_RET;
              st_nxt.wacc_load = 1'b1;
              st_nxt.wacc_data = instr_word[cid_pkg::F_K8_HI:0];
            end
            cid_pkg::OP_RET: begin
              two = 1'b1;
              st_nxt.flow_kind = cid_pkg::FLOW_RET;
            end
            cid_pkg::OP_WDTCLR: begin
              st_nxt.wdt_clear = 1'b1;
              st_nxt.to_flag = 1'b1;
              st_nxt.pd_flag = 1'b1;
            end
            cid_pkg::OP_PRESC: begin
              st_nxt.presc_we = 1'b1;
              st_nxt.cfg_data = wacc_in;
            end
            cid_pkg::OP_SWRST: st_nxt.sw_reset = 1'b1;
            cid_pkg::OP_SLEEP: begin
              st_nxt.wdt_clear = 1'b1;
              st_nxt.standby = 1'b1;
              st_nxt.to_flag = 1'b1;
              st_nxt.pd_flag = 1'b0;
            end
            cid_pkg::OP_DIR: begin
              st_nxt.dir_we = 1'b1;
              st_nxt.dir_sel = instr_word[cid_pkg::F_DIR_HI:0];
              st_nxt.cfg_data = wacc_in;
            end
            cid_pkg::OP_PADD: begin
              upd = ptr_sel + cid_pkg::cid_sext6(k6);
              if (psel) st_nxt.ptr1 = upd;
              else st_nxt.ptr0 = upd;
            end
            cid_pkg::OP_ILD, cid_pkg::OP_IST: begin
              upd = step_ptr(instr_word[cid_pkg::F_PSEL_MOD] ?
                st_r.ptr1 : st_r.ptr0, mode);
              addr = mode[1] ? (instr_word[cid_pkg::F_PSEL_MOD] ?
                st_r.ptr1 : st_r.ptr0) : upd;
              if (instr_word[cid_pkg::F_PSEL_MOD]) st_nxt.ptr1 = upd;
              else st_nxt.ptr0 = upd;
              st_nxt.mem_addr = addr;
              st_nxt.mem_re = (op == cid_pkg::OP_ILD);
              st_nxt.ld_pend = (op == cid_pkg::OP_ILD);
              st_nxt.mem_we = (op == cid_pkg::OP_IST);
              st_nxt.mem_wdata = wacc_in;
              ext = addr[15];
            end
            cid_pkg::OP_ILDX, cid_pkg::OP_ISTX: begin
              addr = ptr_sel + cid_pkg::cid_sext6(k6);
              st_nxt.mem_addr = addr;
              st_nxt.mem_re = (op == cid_pkg::OP_ILDX);
              st_nxt.ld_pend = (op == cid_pkg::OP_ILDX);
              st_nxt.mem_we = (op == cid_pkg::OP_ISTX);
              st_nxt.mem_wdata = wacc_in;
              ext = addr[15];
            end
            default: ;
          endcase
          if (two) st_nxt.phase = PH_NOP;
          else if (ext) st_nxt.phase = PH_EXT;
          else st_nxt.phase = PH_RUN;
        end
      end
      PH_NOP: st_nxt.phase = PH_RUN;
      PH_EXT: st_nxt.phase = PH_RUN;
      default: st_nxt.phase = PH_RUN;
    endcase
    st_nxt.ready = (st_nxt.phase == PH_RUN);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.phase <= PH_RUN;
      st_r.ready <= 1'b1;
      st_r.to_flag <= cid_pkg::CID_TO_RST;
      st_r.pd_flag <= cid_pkg::CID_PD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign fetch_ready_r    = st_r.ready;
  assign flow_kind_r      = st_r.flow_kind;
  assign flow_target_r    = st_r.flow_target;
  assign wacc_load_r      = st_r.wacc_load;
  assign wacc_data_r      = st_r.wacc_data;
  assign zero_we_r        = st_r.zero_we;
  assign zero_val_r       = st_r.zero_val;
  assign wdt_clear_r      = st_r.wdt_clear;
  assign standby_r        = st_r.standby;
  assign sw_reset_r       = st_r.sw_reset;
  assign timeout_flag_r   = st_r.to_flag;
  assign powerdown_flag_r = st_r.pd_flag;
  assign presc_we_r       = st_r.presc_we;
  assign dir_we_r         = st_r.dir_we;
  assign dir_sel_r        = st_r.dir_sel;
  assign cfg_data_r       = st_r.cfg_data;
  assign mem_re_r         = st_r.mem_re;
  assign mem_we_r         = st_r.mem_we;
  assign mem_addr_r       = st_r.mem_addr;
  assign mem_wdata_r      = st_r.mem_wdata;
  assign ptr0_r           = st_r.ptr0;
  assign ptr1_r           = st_r.ptr1;

  // Checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_TWO_CYCLE: assert property (accept && (op == cid_pkg::OP_GOTO ||
      op == cid_pkg::OP_CALL || op == cid_pkg::OP_RET ||
      op == cid_pkg::OP_BRA) |=> !fetch_ready_r ##1 fetch_ready_r)
    else $error("flow op did not take two cycles");

  AST_EXT_CYCLE: assert property (accept && op == cid_pkg::OP_ISTX &&
      st_nxt.mem_addr[15] |=> mem_we_r && !fetch_ready_r
      ##1 fetch_ready_r)
    else $error("high pointer access missed extra cycle");

  AST_BRW_TARGET: assert property (accept && op == cid_pkg::OP_BRW
      |=> flow_kind_r == cid_pkg::FLOW_JUMP && flow_target_r ==
      $past(pc_cur) + 15'h0001 + {7'h00, $past(wacc_in)})
    else $error("wrong accumulator branch target");

  AST_CALL_VIA_ACCUMULATOR: assert property (accept && op == cid_pkg::OP_CALL_VIA_ACCUMULATOR
      |=> flow_kind_r == cid_pkg::FLOW_CALL &&
      flow_target_r[7:0] == $past(wacc_in))
    else $error("accumulator call wrong");

  AST_RETI: assert property (accept && op == cid_pkg::OP_RETI
      |=> flow_kind_r == cid_pkg::FLOW_RETI ##1
      flow_kind_r == cid_pkg::FLOW_NONE)
    else $error("interrupt return not signalled");

  AST_RETURN_WITH_LITERAL: assert property (accept && op == cid_pkg::OP_RETURN_WITH_LITERAL
      |=> wacc_load_r && wacc_data_r == $past(instr_word[7:0]))
    else $error("return literal not loaded");

  AST_WDT_FLAGS: assert property (accept && op == cid_pkg::OP_WDTCLR
      |=> wdt_clear_r && timeout_flag_r && powerdown_flag_r)
    else $error("watchdog clear flags wrong");

  AST_SLEEP_FLAGS: assert property (accept && op == cid_pkg::OP_SLEEP
      |=> standby_r && timeout_flag_r && !powerdown_flag_r)
    else $error("standby flags wrong");

  AST_PADD: assert property (accept && op == cid_pkg::OP_PADD && !psel
      |=> ptr0_r == $past(st_r.ptr0) +
      cid_pkg::cid_sext6($past(instr_word[5:0])))
    else $error("pointer add wrong");

  AST_STORE_NOFLAG: assert property (accept && op == cid_pkg::OP_IST &&
      !st_r.ld_pend |=> mem_we_r && !zero_we_r)
    else $error("indirect store touched flags");

  AST_LOAD_DATA: assert property (accept && op == cid_pkg::OP_ILD
      |=> mem_re_r ##1 wacc_load_r && zero_we_r && zero_val_r ==
      ($past(ind_rdata) == 8'h00) && (wacc_data_r == $past(ind_rdata) ||
      $past(accept && op == cid_pkg::OP_RETURN_WITH_LITERAL)))
    else $error("indirect load not captured");

  COV_CALL: cover property (accept && op == cid_pkg::OP_CALL);
  COV_EXT: cover property (st_r.phase == PH_EXT);
  COV_SLEEP: cover property (accept && op == cid_pkg::OP_SLEEP);
  COV_LOAD: cover property (accept && op == cid_pkg::OP_ILDX);

endmodule // cid_core
`default_nettype wire

/* File: cid_fetch_model.sv */
// Program memory model: instruction words and indirect read data
`timescale 1ns/10ps
`default_nettype none
module cid_fetch_model (
  // Clock, reset and pacing
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  // Fetch handshake
  input  wire logic        fetch_ready_r,
  output logic             instr_valid,
  output logic [13:0]      instr_word,
  output logic [14:0]      pc_cur,
  output logic [7:0]       wacc_in,
  // Indirect read
  input  wire logic        mem_re_r,
  input  wire logic [15:0] mem_addr_r,
  output logic [7:0]       ind_rdata
);
  logic [36:0] q[$];
  logic        tk;
  // Read data follows the address
  function automatic logic [7:0] rd_of(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  // Entry is {pc, accumulator, word}
  task automatic push(input logic [36:0] e);
    q.push_back(e);
  endtask
  initial begin
    instr_valid = 1'b0;
    {pc_cur, wacc_in, instr_word} = 37'h0;
    ind_rdata = 8'h00;
  end
  // Offer held until taken; idle lines keep toggling
  always @(posedge clk) begin
    tk = instr_valid && fetch_ready_r && !rst;
    if (tk) q.delete(0);
    #1;
    ind_rdata = mem_re_r ? rd_of(mem_addr_r) : ~ind_rdata;
    if (rst || ((tk || !instr_valid) &&
        (q.size() == 0 || (slow && $urandom_range(1, 0) == 1)))) begin
      instr_valid = 1'b0;
      {pc_cur, wacc_in, instr_word} = ~{pc_cur, wacc_in, instr_word};
    end else begin
      instr_valid = 1'b1;
      {pc_cur, wacc_in, instr_word} = q[0];
    end
  end
endmodule // cid_fetch_model
`default_nettype wire

/* File: test_control_inherent_op_decoder.sv */
// Self-checking bench for the control instruction sequencer
`timescale 1ns/10ps
`default_nettype none
module test_control_inherent_op_decoder;
  // Word base and operand mask per operation index
  localparam logic [13:0] BASE [18] = '{14'h3200, 14'h000B, 14'h2000,
    14'h000A, 14'h2800, 14'h0009, 14'h3400, 14'h0008, 14'h0064, 14'h0062,
    14'h0001, 14'h0063, 14'h0060, 14'h3100, 14'h0010, 14'h0018, 14'h3F00,
    14'h3F80};
  localparam logic [13:0] MASK [18] = '{14'h01FF, 14'h0000, 14'h07FF,
    14'h0000, 14'h07FF, 14'h0000, 14'h00FF, 14'h0000, 14'h0000, 14'h0000,
    14'h0000, 14'h0000, 14'h0007, 14'h007F, 14'h0007, 14'h0007, 14'h007F,
    14'h007F};
  logic        clk, rst, slow, instr_valid, fetch_ready_r, wacc_load_r;
  logic        zero_we_r, zero_val_r, wdt_clear_r, standby_r, sw_reset_r;
  logic        timeout_flag_r, powerdown_flag_r, presc_we_r, dir_we_r;
  logic        mem_re_r, mem_we_r, pd_m, last_ld;
  logic [2:0]  dir_sel_r;
  logic [7:0]  wacc_in, ind_rdata, wacc_data_r, cfg_data_r, mem_wdata_r;
  logic [13:0] instr_word;
  logic [14:0] pc_cur, flow_target_r;
  logic [15:0] mem_addr_r, ptr0_r, ptr1_r;
  logic [15:0] p [2];
  logic [31:0] q [5][$];
  logic [31:0] g [5];
  logic [4:0]  ev;
  int          errors, n_compared, i;
  cid_pkg::cid_flow_t flow_kind_r;
  cid_core cid_core_inst (
    .clk(clk), .rst(rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .fetch_ready_r(fetch_ready_r),
    .pc_cur(pc_cur), .wacc_in(wacc_in), .ind_rdata(ind_rdata),
    .flow_kind_r(flow_kind_r), .flow_target_r(flow_target_r),
    .wacc_load_r(wacc_load_r), .wacc_data_r(wacc_data_r),
    .zero_we_r(zero_we_r), .zero_val_r(zero_val_r),
    .wdt_clear_r(wdt_clear_r), .standby_r(standby_r),
    .sw_reset_r(sw_reset_r), .timeout_flag_r(timeout_flag_r),
    .powerdown_flag_r(powerdown_flag_r), .presc_we_r(presc_we_r),
    .dir_we_r(dir_we_r), .dir_sel_r(dir_sel_r), .cfg_data_r(cfg_data_r),
    .mem_re_r(mem_re_r), .mem_we_r(mem_we_r), .mem_addr_r(mem_addr_r),
    .mem_wdata_r(mem_wdata_r), .ptr0_r(ptr0_r), .ptr1_r(ptr1_r));
  cid_fetch_model cid_fetch_model_inst (
    .clk(clk), .rst(rst), .slow(slow), .fetch_ready_r(fetch_ready_r),
    .instr_valid(instr_valid), .instr_word(instr_word), .pc_cur(pc_cur),
    .wacc_in(wacc_in), .mem_re_r(mem_re_r), .mem_addr_r(mem_addr_r),
    .ind_rdata(ind_rdata));
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] e, input logic [31:0] v,
                     input string s);
    n_compared++;
    if (v !== e) begin
      errors++;
      $display("[ERR] %0t %s exp %h got %h", $time, s, e, v);
    end
  endtask
  task automatic pop_cmp(input int k, input logic [31:0] v);
    if (q[k].size() == 0) begin
      errors++;
      $display("[ERR] %0t unexpected result of kind %0d", $time, k);
    end else begin
      cmp(q[k].pop_front(), v, $sformatf("kind %0d", k));
    end
  endtask
  task automatic nt(input int k, input logic [31:0] v);
    q[k].push_back(v);
  endtask
  task automatic fl(input cid_pkg::cid_flow_t k, input logic [14:0] t);
    nt(0, 32'({1'b0, k, t}));
  endtask
  // Build one word, note its expected results, hand it to memory
  task automatic issue(input int op, input logic [13:0] fr = 14'h0000);
    logic [13:0] r, w;
    logic [14:0] pc;
    logic [15:0] a, d;
    logic [7:0]  wa, rd;
    logic        n;
    r = (fr != 14'h0000) ? fr : 14'($urandom);
    pc = 15'($urandom);
    wa = 8'($urandom);
    if (op == 12 && r[2:0] inside {[3'h2:3'h4]}) r[2] = ~r[2];
    w = BASE[op] | (r & MASK[op]);
    if (op == 14 || op == 15) begin
      n = w[cid_pkg::F_PSEL_MOD];
      d = w[0] ? 16'hFFFF : 16'h0001;
      a = w[1] ? p[n] : p[n] + d;
      p[n] = p[n] + d;
    end else begin
      n = w[cid_pkg::F_PSEL_IDX];
      a = p[n] + {{10{w[5]}}, w[5:0]};
    end
    rd = cid_fetch_model_inst.rd_of(a);
    if (op == 11 || op == 8) pd_m = (op == 8);
    if (op == 6 && last_ld) cid_fetch_model_inst.push(37'h0);
    last_ld = (op == 14 || op == 16);
    case (op)
      0: fl(cid_pkg::FLOW_JUMP, pc + 15'h0001 + {{6{w[8]}}, w[8:0]});
      1: fl(cid_pkg::FLOW_JUMP, pc + 15'h0001 + {7'h00, wa});
      2: fl(cid_pkg::FLOW_CALL, {pc[14:11], w[10:0]});
      3: fl(cid_pkg::FLOW_CALL, {pc[14:8], wa});
      4: fl(cid_pkg::FLOW_JUMP, {pc[14:11], w[10:0]});
      5: fl(cid_pkg::FLOW_RETI, 15'h0000);
      6: begin
        fl(cid_pkg::FLOW_RET, 15'h0000);
        nt(1, 32'({3'b100, w[7:0]}));
      end
      7: fl(cid_pkg::FLOW_RET, 15'h0000);
      8: nt(4, 32'({4'b1001, pd_m}));
      9: nt(2, 32'({5'b10000, wa}));
      10: nt(4, 32'({4'b0011, pd_m}));
      11: nt(4, 32'({4'b1101, pd_m}));
      12: nt(2, 32'({2'b01, w[2:0], wa}));
      13: p[n] = a;
      14, 16: begin
        nt(3, 32'({~a[15], 2'b10, a, 8'h00}));
        nt(1, 32'({2'b11, rd == 8'h00, rd}));
      end
      default: nt(3, 32'({~a[15], 2'b01, a, wa}));
    endcase
    cid_fetch_model_inst.push({pc, wa, w});
  endtask
  task automatic chk_rst();
    @(negedge clk);
    cmp(32'h7, 32'({fetch_ready_r, timeout_flag_r,
      powerdown_flag_r}), "rst");
    cmp(32'h0, 32'({ptr0_r, ptr1_r}), "rst ptr");
    cmp(32'h0, 32'({flow_kind_r, mem_re_r, mem_we_r,
      wacc_load_r}), "rst");
    @(posedge clk);
    #1;
  endtask
  task automatic drain();
    int t;
    for (t = 0; t < 4000 && cid_fetch_model_inst.q.size() != 0; t++)
      @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    if (t == 4000) begin
      errors++;
      $display("[ERR] %0t fetch queue never drained", $time);
      give_verdict();
    end
    for (t = 0; t < 5; t++) cmp(32'h0, 32'(q[t].size()), "leftover");
    cmp(32'(p[0]), 32'(ptr0_r), "ptr0");
    cmp(32'(p[1]), 32'(ptr1_r), "ptr1");
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Observed results packed per kind
  always_comb begin
    g[0] = 32'({fetch_ready_r, flow_kind_r, (flow_kind_r == cid_pkg::FLOW_JUMP
      || flow_kind_r == cid_pkg::FLOW_CALL) ? flow_target_r : 15'h0000});
    g[1] = 32'({wacc_load_r, zero_we_r, zero_we_r & zero_val_r, wacc_data_r});
    g[2] = 32'({presc_we_r, dir_we_r, dir_we_r ? dir_sel_r : 3'h0, cfg_data_r});
    g[3] = 32'({fetch_ready_r, mem_re_r, mem_we_r, mem_addr_r,
      mem_we_r ? mem_wdata_r : 8'h00});
    g[4] = 32'({wdt_clear_r, standby_r, sw_reset_r, timeout_flag_r,
      powerdown_flag_r});
    ev[0] = flow_kind_r !== cid_pkg::FLOW_NONE;
    ev[1] = (wacc_load_r | zero_we_r) !== 1'b0;
    ev[2] = (presc_we_r | dir_we_r) !== 1'b0;
    ev[3] = (mem_re_r | mem_we_r) !== 1'b0;
    ev[4] = (wdt_clear_r | sw_reset_r) !== 1'b0;
  end
  // Each result takes the oldest note of its kind
  always @(negedge clk) begin
    if (rst === 1'b0) begin
      if (ev[0]) pop_cmp(0, g[0]);
      if (ev[1]) pop_cmp(1, g[1]);
      if (ev[2]) pop_cmp(2, g[2]);
      if (ev[3]) pop_cmp(3, g[3]);
      if (ev[4]) pop_cmp(4, g[4]);
    end
  end
  // Main sequence
  initial begin
    void'($urandom(13112));
    rst = 1'b1;
    slow = 1'b0;
    pd_m = 1'b1;
    last_ld = 1'b0;
    p[0] = 16'h0000;
    p[1] = 16'h0000;
    errors = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk_rst();
    // Zero read at pointer 0, then pre-decrement wrap below zero
    issue(14, 14'h0002);
    issue(14, 14'h0005);
    for (i = 0; i < 18; i++) issue(i);
    for (i = 0; i < 200; i++) issue($urandom_range(17, 0));
    drain();
    slow = 1'b1;
    for (i = 0; i < 150; i++) issue($urandom_range(17, 0));
    drain();
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    chk_rst();
    give_verdict();
  end
endmodule // test_control_inherent_op_decoder
`default_nettype wire
